// >>> hdl/bthw_regs.sv
// bridge header window register slice for one switch port
module bthw_regs #(
    parameter bit UPSTREAM = 1'b1,                    // port faces the root
    parameter logic [1:0] MAP_TYPE = bthw_pkg::MAP_32, // strap for base width
    parameter logic [3:0] IO_CAP = bthw_pkg::IO_CAP_32 // I/O decode width
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic dn_io_valid,
    input wire logic [31:0] dn_io_addr,
    output logic dn_io_forward,
    input wire logic up_io_valid,
    input wire logic [31:0] up_io_addr,
    output logic up_io_forward,
    input wire logic poison_cpl_rcvd,
    input wire logic poison_wr_fwd,
    output logic poison_status_set
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_meta;  // first stage, read only by rst_sync
    logic rst_sync;  // released reset used by the core

    // assert at once, release two edges later
    // one release edge for all
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
        end
    end

    // second stage of the release
    // only reader of rst_meta
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 1'b0;
        end else begin
            rst_sync <= rst_meta;
        end
    end

    // ----------------------------------------
    // storage
    // ----------------------------------------
    // fixed fields own no flops

    logic [7:0] cache_line;        // scratch byte, no effect on logic
    logic io_enable;               // primary I/O access enable
    logic par_resp_en;             // bridge parity response enable
    logic [14:0] bar_addr_lo;      // window base bits 31:17
    logic [31:0] bar_addr_hi;      // window base bits 63:32
    logic [7:0] pri_bus;           // primary bus number
    logic [7:0] sec_bus;           // secondary bus number
    logic [7:0] sub_bus;           // subordinate bus number
    logic [3:0] io_base_addr;      // I/O base bits 15:12
    logic [3:0] io_limit_addr;     // I/O limit bits 15:12
    logic par_flag;                // secondary parity flag
    logic [15:0] io_base_upper;    // I/O base bits 31:16
    logic [15:0] io_limit_upper;   // I/O limit bits 31:16

    // ----------------------------------------
    // derived conditions
    // ----------------------------------------
    // straps fold to constants
    wire logic bar_hi_wr_ok;   // high base may take writes
    wire logic io_32bit;       // upper halves take part in decode
    wire logic par_set;        // a parity event counts this cycle
    wire logic poison_any;     // either poisoned event present

    // high base only upstream and only for a 64-bit map
    // a 32-bit build keeps it zero
    assign bar_hi_wr_ok = UPSTREAM && (MAP_TYPE == bthw_pkg::MAP_64);

    // upper halves join decode
    assign io_32bit = (IO_CAP == bthw_pkg::IO_CAP_32);

    // either poisoned event
    assign poison_any = poison_cpl_rcvd || poison_wr_fwd;
    // gated by the enable so the flag never sets while it is off
    assign par_set = par_resp_en && poison_any;

    // ----------------------------------------
    // write strobes
    // ----------------------------------------
    // unmapped writes match none
    wire logic wr_cmd;     // command word
    wire logic wr_misc;    // miscellaneous control word
    wire logic wr_bar_lo;  // low base word
    wire logic wr_bar_hi;  // high base word
    wire logic wr_bus;     // bus number word
    wire logic wr_sec_io;  // status and I/O window word
    wire logic wr_io_up;   // I/O upper halves word
    wire logic wr_brctl;   // bridge control word

    assign wr_cmd = reg_wr && (reg_addr == bthw_pkg::OFS_CMD);
    assign wr_misc = reg_wr && (reg_addr == bthw_pkg::OFS_MISC);

    // downstream ports ignore writes to the base pair
    assign wr_bar_lo = reg_wr && UPSTREAM && (reg_addr == bthw_pkg::OFS_BASE_LO);
    assign wr_bar_hi = reg_wr && bar_hi_wr_ok && (reg_addr == bthw_pkg::OFS_BASE_HI);

    assign wr_bus = reg_wr && (reg_addr == bthw_pkg::OFS_BUS);
    assign wr_sec_io = reg_wr && (reg_addr == bthw_pkg::OFS_SEC_IO);

    // upper halves only writable while 32-bit decode is on
    assign wr_io_up = reg_wr && io_32bit && (reg_addr == bthw_pkg::OFS_IO_UP);
    assign wr_brctl = reg_wr && (reg_addr == bthw_pkg::OFS_BRCTL);

    // ----------------------------------------
    // control and scratch registers
    // ----------------------------------------
    // I/O off until enabled
    // cache byte is only scratch
    // only the writable bits are taken; fixed bits have no storage
    always_ff @(posedge clock or negedge rst_sync) begin
        if (!rst_sync) begin
            io_enable <= 1'b0;
            cache_line <= bthw_pkg::RST_CACHE;
            par_resp_en <= 1'b0;
        end else begin
            if (wr_cmd) begin
                io_enable <= reg_wdata[bthw_pkg::POS_IO_EN];
            end
            if (wr_misc) begin
                cache_line <= reg_wdata[7:0];
            end
            if (wr_brctl) begin
                par_resp_en <= reg_wdata[bthw_pkg::POS_PAR_EN];
            end
        end
    end

    // ----------------------------------------
    // configuration window base pair
    // ----------------------------------------
    // writable upstream only
    // bits below 17 are not stored, so they can never read back
    always_ff @(posedge clock or negedge rst_sync) begin
        if (!rst_sync) begin
            bar_addr_lo <= bthw_pkg::RST_BAR_LO;
            bar_addr_hi <= bthw_pkg::RST_BAR_HI;
        end else begin
            if (wr_bar_lo) begin
                bar_addr_lo <= reg_wdata[31:bthw_pkg::POS_BAR_ADDR];
            end
            if (wr_bar_hi) begin
                bar_addr_hi <= reg_wdata;
            end
        end
    end

    // ----------------------------------------
    // bus numbers
    // ----------------------------------------
    // software owned bytes
    // top byte has no storage and is dropped on write
    always_ff @(posedge clock or negedge rst_sync) begin
        if (!rst_sync) begin
            pri_bus <= bthw_pkg::RST_BUS;
            sec_bus <= bthw_pkg::RST_BUS;
            sub_bus <= bthw_pkg::RST_BUS;
        end else if (wr_bus) begin
            pri_bus <= reg_wdata[7:0];
            sec_bus <= reg_wdata[15:8];
            sub_bus <= reg_wdata[23:16];
        end
    end

    // ----------------------------------------
    // I/O window bounds
    // ----------------------------------------
    // decode reads these live
    // new bounds act from the edge after the write
    always_ff @(posedge clock or negedge rst_sync) begin
        if (!rst_sync) begin
            io_base_addr <= bthw_pkg::RST_IO_BASE;
            io_limit_addr <= bthw_pkg::RST_IO_LIM;
            io_base_upper <= bthw_pkg::RST_IO_UPPER;
            io_limit_upper <= bthw_pkg::RST_IO_UPPER;
        end else begin
            if (wr_sec_io) begin
                io_base_addr <= reg_wdata[7:4];
                io_limit_addr <= reg_wdata[15:12];
            end
            if (wr_io_up) begin
                io_base_upper <= reg_wdata[15:0];
                io_limit_upper <= reg_wdata[31:16];
            end
        end
    end

    // ----------------------------------------
    // secondary parity flag
    // ----------------------------------------
    // set wins over clear
    // set only through the gate
    wire logic par_clr;     // software asks for a clear
    wire logic next_par;    // flag value after this edge

    assign par_clr = wr_sec_io && reg_wdata[bthw_pkg::POS_PAR_FLAG];

    // a set in the clearing cycle wins so no event is lost
    assign next_par = par_set || (par_flag && !par_clr);

    // flag holds until written with a one
    always_ff @(posedge clock or negedge rst_sync) begin
        if (!rst_sync) begin
            par_flag <= 1'b0;
        end else begin
            par_flag <= next_par;
        end
    end

    // native poisoned status sees every event, flag sees gated ones
    // so gated-off events are kept
    always_ff @(posedge clock or negedge rst_sync) begin
        if (!rst_sync) begin
            poison_status_set <= 1'b0;
        end else begin
            poison_status_set <= poison_any;
        end
    end

    // ----------------------------------------
    // read words
    // ----------------------------------------
    // fixed fields tied here
    wire logic [31:0] rd_cmd;     // command word image
    wire logic [31:0] rd_misc;    // miscellaneous control image
    wire logic [31:0] rd_bar_lo;  // low base image
    wire logic [31:0] rd_bar_hi;  // high base image
    wire logic [31:0] rd_bus;     // bus number image
    wire logic [31:0] rd_sec_io;  // status and window image
    wire logic [31:0] rd_io_up;   // upper halves image
    wire logic [31:0] rd_brctl;   // bridge control image

    // only the enable bit is kept
    assign rd_cmd = {31'h0000_0000, io_enable};

    // self-test byte and header-type bit are constant zero
    assign rd_misc = {8'h00, 1'b0, bthw_pkg::LAYOUT_TYPE1, 8'h00, cache_line};

    // space and prefetch bits fixed zero, map type from the strap
    assign rd_bar_lo = UPSTREAM ?
        {bar_addr_lo, 13'h0000, 1'b0, MAP_TYPE, 1'b0} :
        bthw_pkg::ZERO_WORD;
    // zero unless the port is upstream and the map is 64 bits wide
    assign rd_bar_hi = bar_hi_wr_ok ? bar_addr_hi : bthw_pkg::ZERO_WORD;

    // latency byte is not stored and reads zero
    assign rd_bus = {8'h00, sub_bus, sec_bus, pri_bus};

    // reserved status bits sit as constant zero around the flag
    assign rd_sec_io = {4'h0, 3'h0, par_flag, 8'h00,
        io_limit_addr, IO_CAP, io_base_addr, IO_CAP};

    // 16-bit builds read zero
    assign rd_io_up = io_32bit ? {io_limit_upper, io_base_upper} : bthw_pkg::ZERO_WORD;
    assign rd_brctl = {15'h0000, par_resp_en, 16'h0000};

    // ----------------------------------------
    // read select and data register
    // ----------------------------------------
    // zero for idle cycles
    logic [31:0] next_rdata;  // word chosen for the next cycle

    // unmapped offsets answer with zero
    always_comb begin
        next_rdata = bthw_pkg::ZERO_WORD;
        // no lingering data
        if (!reg_rd) begin
            next_rdata = bthw_pkg::ZERO_WORD;
        end else if (reg_addr == bthw_pkg::OFS_CMD) begin
            next_rdata = rd_cmd;
        end else if (reg_addr == bthw_pkg::OFS_MISC) begin
            next_rdata = rd_misc;
        end else if (reg_addr == bthw_pkg::OFS_BASE_LO) begin
            next_rdata = rd_bar_lo;
        end else if (reg_addr == bthw_pkg::OFS_BASE_HI) begin
            next_rdata = rd_bar_hi;
        end else if (reg_addr == bthw_pkg::OFS_BUS) begin
            next_rdata = rd_bus;
        end else if (reg_addr == bthw_pkg::OFS_SEC_IO) begin
            next_rdata = rd_sec_io;
        end else if (reg_addr == bthw_pkg::OFS_IO_UP) begin
            next_rdata = rd_io_up;
        end else if (reg_addr == bthw_pkg::OFS_BRCTL) begin
            next_rdata = rd_brctl;
        end
    end

    // data stands only in the cycle after the read strobe
    // one flop keeps timing easy
    always_ff @(posedge clock or negedge rst_sync) begin
        if (!rst_sync) begin
            reg_rdata <= bthw_pkg::ZERO_WORD;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ----------------------------------------
    // window assembly and decoder
    // ----------------------------------------
    // full 32-bit bounds
    // 16-bit builds zero the top
    wire logic [15:0] base_upper_eff;   // upper base used in decode
    wire logic [15:0] limit_upper_eff;  // upper limit used in decode

    // 16-bit decode treats the upper halves as zero
    assign base_upper_eff = io_32bit ? io_base_upper : bthw_pkg::RST_IO_UPPER;
    assign limit_upper_eff = io_32bit ? io_limit_upper : bthw_pkg::RST_IO_UPPER;

    // bundle to the decoder
    bthw_win_if win ();

    // low 12 bits fixed: base rounds down, limit rounds up
    assign win.base = {base_upper_eff, io_base_addr, bthw_pkg::IO_BASE_LOW};
    assign win.limit = {limit_upper_eff, io_limit_addr, bthw_pkg::IO_LIM_LOW};

    // decode reads live registers, so a write is seen next cycle
    assign win.io_enable = io_enable;

    // requests pass through
    assign win.dn_valid = dn_io_valid;
    assign win.dn_addr = dn_io_addr;
    assign win.up_valid = up_io_valid;
    assign win.up_addr = up_io_addr;

    // combinational: forwarding answers in the request cycle
    // no flop on this path
    bthw_io_decode u_decode (
        .win(win)
    );

    // forwards leave unregistered
    assign dn_io_forward = win.dn_forward;
    assign up_io_forward = win.up_forward;
endmodule

// >>> hdl/bthw_pkg.sv
// constants shared by the bridge header window register slice
package bthw_pkg;
    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_MISC = 8'h0C;
    localparam logic [7:0] OFS_BASE_LO = 8'h10;
    localparam logic [7:0] OFS_BASE_HI = 8'h14;
    localparam logic [7:0] OFS_BUS = 8'h18;
    localparam logic [7:0] OFS_SEC_IO = 8'h1C;
    localparam logic [7:0] OFS_IO_UP = 8'h30;
    localparam logic [7:0] OFS_BRCTL = 8'h3C;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int POS_IO_EN = 0;
    localparam int POS_LAYOUT = 16;
    localparam int POS_MAP = 1;
    localparam int POS_BAR_ADDR = 17;
    localparam int POS_IO_BASE = 4;
    localparam int POS_IO_LCAP = 8;
    localparam int POS_IO_LIM = 12;
    localparam int POS_PAR_FLAG = 24;
    localparam int POS_PAR_EN = 16;
    // ----------------------------------------
    // fixed encodings and reset values
    // ----------------------------------------
    localparam logic [6:0] LAYOUT_TYPE1 = 7'h01;
    localparam logic [1:0] MAP_32 = 2'h0;
    localparam logic [1:0] MAP_64 = 2'h2;
    localparam logic [3:0] IO_CAP_32 = 4'h1;
    localparam logic [3:0] RST_IO_BASE = 4'hF;
    localparam logic [3:0] RST_IO_LIM = 4'h0;
    localparam logic [7:0] RST_BUS = 8'h00;
    localparam logic [7:0] RST_CACHE = 8'h00;
    localparam logic [14:0] RST_BAR_LO = 15'h0000;
    localparam logic [31:0] RST_BAR_HI = 32'h0000_0000;
    localparam logic [15:0] RST_IO_UPPER = 16'h0000;
    localparam logic [11:0] IO_BASE_LOW = 12'h000;
    localparam logic [11:0] IO_LIM_LOW = 12'hFFF;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

// >>> hdl/bthw_win_if.sv
// window bounds and I/O requests between register slice and decoder
interface bthw_win_if;
    logic [31:0] base;     // full 32-bit window base
    logic [31:0] limit;    // full 32-bit window limit
    logic io_enable;       // primary-side I/O access enable
    logic dn_valid;        // primary-side request present
    logic [31:0] dn_addr;  // primary-side request address
    logic dn_forward;      // pass request downstream
    logic up_valid;        // secondary-side request present
    logic [31:0] up_addr;  // secondary-side request address
    logic up_forward;      // pass request upstream
    modport ctrl (
        output base, limit, io_enable, dn_valid, dn_addr, up_valid, up_addr,
        input dn_forward, up_forward
    );
    modport dec (
        input base, limit, io_enable, dn_valid, dn_addr, up_valid, up_addr,
        output dn_forward, up_forward
    );
endinterface

// >>> hdl/bthw_io_decode.sv
// I/O base-to-limit forwarding decision for both directions
module bthw_io_decode (
    bthw_win_if.dec win
);
    // ----------------------------------------
    // window test
    // ----------------------------------------
    // inside only when base <= addr <= limit; an inverted window holds nothing
    function automatic logic in_window(
        input logic [31:0] addr,
        input logic [31:0] base,
        input logic [31:0] limit
    );
        in_window = (addr >= base) && (addr <= limit);
    endfunction

    wire logic dn_hit;  // primary address inside window
    wire logic up_hit;  // secondary address inside window

    assign dn_hit = in_window(win.dn_addr, win.base, win.limit);
    assign up_hit = in_window(win.up_addr, win.base, win.limit);

    // ----------------------------------------
    // forwarding
    // ----------------------------------------
    // downstream needs the access enable and a hit
    assign win.dn_forward = win.dn_valid && win.io_enable && dn_hit;
    // upstream passes everything that misses, all of it if inverted
    assign win.up_forward = win.up_valid && !up_hit;
endmodule

// >>> test/bthw_regs_asserts.sv
// concurrent port checks for the bridge header window register slice
module bthw_regs_asserts #(
    parameter bit UPSTREAM = 1'b1,
    parameter logic [1:0] MAP_TYPE = bthw_pkg::MAP_32
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic dn_io_valid,
    input wire logic [31:0] dn_io_addr,
    input wire logic dn_io_forward,
    input wire logic up_io_valid,
    input wire logic [31:0] up_io_addr,
    input wire logic up_io_forward,
    input wire logic poison_cpl_rcvd,
    input wire logic poison_wr_fwd,
    input wire logic poison_status_set
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // helper state: which word the last read strobe asked for
    // ----------------------------------------
    logic rd_d;       // read strobe one cycle back
    logic [7:0] addr_d; // its address
    // fixed low bits of the base word; downstream ports hide the map type
    localparam logic [16:0] LOW_BITS = {14'h0000, (UPSTREAM ? MAP_TYPE : 2'b00), 1'b0};
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // capture strobe and address, cleared with the port reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_d <= 1'b0;
            addr_d <= 8'h00;
        end else begin
            rd_d <= reg_rd;
            addr_d <= reg_addr;
        end
    end
    // ----------------------------------------
    // read-back of fixed fields
    // ----------------------------------------
    property p_misc_fixed;
        rd_d && addr_d == bthw_pkg::OFS_MISC |-> reg_rdata[31:16] == 16'h0001;
    endproperty
    a_misc_fixed: assert property (p_misc_fixed) else $error("misc word fixed bits wrong");
    property p_base_low;
        rd_d && addr_d == bthw_pkg::OFS_BASE_LO
            |-> reg_rdata[16:0] == LOW_BITS && (UPSTREAM || reg_rdata[31:17] == 15'h0000);
    endproperty
    a_base_low: assert property (p_base_low) else $error("base low fixed bits wrong");
    property p_base_high;
        $past(reg_rd) && $past(reg_addr) == bthw_pkg::OFS_BASE_HI
            && !(UPSTREAM && MAP_TYPE == bthw_pkg::MAP_64) |-> reg_rdata == 32'h0000_0000;
    endproperty
    a_base_high: assert property (p_base_high) else $error("base high not zero");
    property p_bus_top;
        rd_d && addr_d == bthw_pkg::OFS_BUS |-> reg_rdata[31:24] == 8'h00;
    endproperty
    a_bus_top: assert property (p_bus_top) else $error("latency byte not zero");
    property p_sec_io;
        rd_d && addr_d == bthw_pkg::OFS_SEC_IO |-> reg_rdata[3:0] == 4'h1
            && reg_rdata[11:8] == 4'h1 && reg_rdata[23:16] == 8'h00 && reg_rdata[31:25] == 7'h00;
    endproperty
    a_sec_io: assert property (p_sec_io) else $error("status or capability bits wrong");
    property p_unmapped;
        rd_d && addr_d > bthw_pkg::OFS_BRCTL |-> reg_rdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // ----------------------------------------
    // poison mirror and forwarding
    // ----------------------------------------
    property p_poison_set;
        poison_cpl_rcvd || poison_wr_fwd |=> poison_status_set;
    endproperty
    a_poison_set: assert property (p_poison_set) else $error("poison event not mirrored");
    property p_poison_cause;
        poison_status_set |-> $past(poison_cpl_rcvd || poison_wr_fwd);
    endproperty
    a_poison_cause: assert property (p_poison_cause) else $error("mirror pulse without cause");
    property p_dn_gate;
        !dn_io_valid |-> !dn_io_forward;
    endproperty
    a_dn_gate: assert property (p_dn_gate) else $error("forward down without request");
    property p_one_way;
        dn_io_valid && up_io_valid && dn_io_addr == up_io_addr |-> !(dn_io_forward && up_io_forward);
    endproperty
    a_one_way: assert property (p_one_way) else $error("address forwarded both ways");
    c_flag_read: cover property (rd_d && addr_d == bthw_pkg::OFS_SEC_IO && reg_rdata[24]);
    c_dn_fwd: cover property (dn_io_forward);
    c_up_fwd: cover property (up_io_forward);
    c_poison: cover property (poison_status_set);
endmodule

// >>> test/bthw_regs_bench.sv
// self-checking bench for the bridge header window register slice
module bthw_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_n, reg_wr, reg_rd, dn_io_valid, up_io_valid, poison_cpl_rcvd, poison_wr_fwd;
    logic dn_io_forward, up_io_forward, poison_status_set;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rdata64, dn_io_addr, up_io_addr, rv, rv64;
    int bad_count = 0;
    int compares = 0;
    // 32-bit strapped port under test
    bthw_regs dut (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .dn_io_valid(dn_io_valid), .dn_io_addr(dn_io_addr), .dn_io_forward(dn_io_forward),
        .up_io_valid(up_io_valid), .up_io_addr(up_io_addr), .up_io_forward(up_io_forward),
        .poison_cpl_rcvd(poison_cpl_rcvd), .poison_wr_fwd(poison_wr_fwd),
        .poison_status_set(poison_status_set));
    // 64-bit strapped twin on the same inputs; only its read data is compared
    bthw_regs #(.MAP_TYPE(bthw_pkg::MAP_64)) dut64 (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata64),
        .dn_io_valid(dn_io_valid), .dn_io_addr(dn_io_addr), .dn_io_forward(),
        .up_io_valid(up_io_valid), .up_io_addr(up_io_addr), .up_io_forward(),
        .poison_cpl_rcvd(poison_cpl_rcvd), .poison_wr_fwd(poison_wr_fwd), .poison_status_set());
    // ----------------------------------------
    // clock, verdict and bus tasks
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic wrap_up();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            bad_count++;
        end
    endtask
    // one-cycle write strobe; a gap edge follows before the next request
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
        rv64 = rdata64;
    endtask
    // same address offered on both sides; forwards are combinational
    task automatic io(input logic [31:0] a, input logic dn, input logic up);
        @(posedge clock);
        dn_io_addr <= a;
        up_io_addr <= a;
        dn_io_valid <= 1'b1;
        up_io_valid <= 1'b1;
        #1;
        chk({31'h0, dn_io_forward}, {31'h0, dn});
        chk({31'h0, up_io_forward}, {31'h0, up});
    endtask
    // one-cycle poison pulse, mirror pulse expected in the following cycle
    task automatic poke(input logic cpl);
        @(posedge clock);
        poison_cpl_rcvd <= cpl;
        poison_wr_fwd <= !cpl;
        @(posedge clock);
        poison_cpl_rcvd <= 1'b0;
        poison_wr_fwd <= 1'b0;
        #1;
        chk({31'h0, poison_status_set}, 32'h0000_0001);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {rst_n, reg_wr, reg_rd, dn_io_valid, up_io_valid, poison_cpl_rcvd, poison_wr_fwd} = '0;
        reg_addr = 8'h00;
        {reg_wdata, dn_io_addr, up_io_addr} = '0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        // core leaves reset two edges after release
        repeat (2) @(posedge clock);
        rd(8'h0C);
        chk(rv, 32'h0001_0000);
        rd(8'h10);
        chk(rv, 32'h0000_0000);
        chk(rv64, 32'h0000_0004);
        rd(8'h18);
        chk(rv, 32'h0000_0000);
        rd(8'h1C);
        chk(rv, 32'h0000_01F1);
        // all-ones writes, a pattern to the bus word: only writable fields may move
        wr(8'h0C, 32'hFFFF_FFFF);
        rd(8'h0C);
        chk(rv, 32'h0001_00FF);
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10);
        chk(rv, 32'hFFFE_0000);
        chk(rv64, 32'hFFFE_0004);
        wr(8'h14, 32'hFFFF_FFFF);
        rd(8'h14);
        chk(rv, 32'h0000_0000);
        chk(rv64, 32'hFFFF_FFFF);
        wr(8'h18, 32'hAB12_3456);
        rd(8'h18);
        chk(rv, 32'h0012_3456);
        wr(8'h1C, 32'hFFFF_FFFF);
        rd(8'h1C);
        chk(rv, 32'h0000_F1F1);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40);
        chk(rv, 32'h0000_0000);
        // window 0001_4000 .. 0002_8FFF with upper halves in use
        wr(8'h30, 32'h0002_0001);
        rd(8'h30);
        chk(rv, 32'h0002_0001);
        wr(8'h1C, 32'h0000_8040);
        io(32'h0001_5000, 1'b0, 1'b0);
        wr(8'h04, 32'h0000_0001);
        io(32'h0001_3FFF, 1'b0, 1'b1);
        io(32'h0001_4000, 1'b1, 1'b0);
        io(32'h0002_8FFF, 1'b1, 1'b0);
        io(32'h0002_9000, 1'b0, 1'b1);
        io(32'h0000_5000, 1'b0, 1'b1);
        // limit below base: nothing down, everything up
        wr(8'h30, 32'h0000_0000);
        wr(8'h1C, 32'h0000_00F0);
        io(32'h0000_0800, 1'b0, 1'b1);
        io(32'h0000_F800, 1'b0, 1'b1);
        @(posedge clock);
        dn_io_valid <= 1'b0;
        up_io_valid <= 1'b0;
        // parity flag: ignored while response is off, then set, held, cleared
        poke(1'b1);
        rd(8'h1C);
        chk(rv, 32'h0000_01F1);
        wr(8'h3C, 32'h0001_0000);
        poke(1'b0);
        rd(8'h1C);
        chk(rv, 32'h0100_01F1);
        wr(8'h1C, 32'h0000_00F0);
        rd(8'h1C);
        chk(rv, 32'h0100_01F1);
        wr(8'h1C, 32'h0100_00F0);
        rd(8'h1C);
        chk(rv, 32'h0000_01F1);
        poke(1'b1);
        rd(8'h1C);
        chk(rv, 32'h0100_01F1);
        wrap_up();
    end
    // watchdog: the sequence needs under a hundred cycles
    initial begin
        repeat (3000) @(posedge clock);
        bad_count++;
        wrap_up();
    end
endmodule
bind bthw_regs bthw_regs_asserts #(.UPSTREAM(UPSTREAM), .MAP_TYPE(MAP_TYPE)) u_chk (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dn_io_valid(dn_io_valid), .dn_io_addr(dn_io_addr), .dn_io_forward(dn_io_forward),
    .up_io_valid(up_io_valid), .up_io_addr(up_io_addr), .up_io_forward(up_io_forward),
    .poison_cpl_rcvd(poison_cpl_rcvd), .poison_wr_fwd(poison_wr_fwd),
    .poison_status_set(poison_status_set));
